// *** rtl/adr_bank.sv ***
// Purpose: Result, modulator, start delay, amplifier and status/communication registers of a delta-sigma front end
// Assumes: Converter core strobes results and modulator ticks; registers on classic Wishbone
// Notes: Serial framing is outside; its mode bits are exported as plain outputs
// Function
// - Result register keeps latest result, frozen during reads, newest captured after read.
// - All three result bytes refresh together; bytes readable individually.
// - Result shows corrected data when offset or gain correction is enabled.
// - Output width code selects 32 sign, 32 zero pad, 24 or rounded 16 bit.
// - Modulator bits follow comparators each modulator tick; reset equals zero-volt code.
// - Any start delay write resets and restarts the converter.
// - Start delay equals delay code plus half oversampling ratio in modulator periods.
// - Read increment field selects map, type, group or static looping.
// - Write increment bit selects looping over writable registers or static address.
// - Idle ready pin driven high when idle drive bit set, else released.
// - Checksum width bit selects 32-bit field with zero pad, else 16-bit.
// - Transfer checksum enable appends CRC-16 to every transfer.
// - Map checksum mismatch with interrupt enabled holds ready pin low.
// - Latched checksum alarm clears only on writing unlock key to lock field.
// - Map checksum stays computed and readable with interrupt disabled.
// - Bitstream enable bit switches the bitstream output pin on or off.
// - Ready flag reads 0 with new data, returns 1 after status read, resets 1.
// - Reading the result alone leaves the ready flag unchanged.
// - Unimplemented bits ignore writes and read zero.
// - Offset correction adds signed offset to converter code with no delay; not applied while gain correction is enabled.
// - Gain correction delays data and ready pulse by 24 modulator periods.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "adr_defines.svh"

module adr_bank
    import adr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [6:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Converter core
    input wire logic mod_tick_i,
    input wire logic [3:0] comparator_outputs_i,
    input wire logic conv_valid_i,
    input wire logic [23:0] conv_code_i,
    input wire logic [23:0] gain_fix_code_i,
    input wire logic [2:0] oversampling_ratio_i,
    input wire logic serial_read_busy_i,
    input wire logic crc_mismatch_i,
    input wire logic [15:0] map_checksum_i,
    output logic conv_restart_o,
    output logic start_pending_o,
    output logic [5:0] amplifier_gain_o,
    output logic [31:0] result_code_o,
    // Serial port mode
    output logic [1:0] read_incr_o,
    output logic write_incr_o,
    output logic crc_wide_o,
    output logic transfer_checksum_enable_o,
    // Pins
    input wire logic bitstream_i,
    output logic ready_pin_n_o,
    output logic ready_pin_n_oe_o,
    output logic bitstream_out_pin_o
);

    // ==========================================================================
    // Helpers
    function automatic logic [31:0] fmt_result(input logic [23:0] d, input logic [1:0] w);
        logic [24:0] r;
        r = {d[23], d} + 25'h0000080;
        unique case (w)
            2'b11: fmt_result = {{8{d[23]}}, d};
            2'b10: fmt_result = {d, 8'h00};
            2'b01: fmt_result = {8'h00, d};
            // Saturate instead of wrapping when rounding overflows the top code
            default: fmt_result = {16'h0000, (r[24] != r[23]) ? 16'h7FFF : r[23:8]};
        endcase
    endfunction : fmt_result

    function automatic logic [5:0] amp_gain(input logic [2:0] c);
        unique case (c)
            3'b000: amp_gain = 6'h01;
            3'b001: amp_gain = 6'h02;
            3'b010: amp_gain = 6'h04;
            3'b011: amp_gain = 6'h08;
            3'b100: amp_gain = 6'h10;
            3'b101: amp_gain = 6'h20;
            default: amp_gain = 6'h01;
        endcase
    endfunction : amp_gain

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            lane_merge[i*8 +: 8] = s[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : lane_merge

    // ==========================================================================
    // State
    adr_state_t q;
    adr_state_t next_q;
    logic [4:0] idx;
    logic req;
    logic [23:0] fixed;
    logic [23:0] stored;
    logic new_data;
    logic [31:0] wr;
    logic [12:0] half_osr;

    assign idx = adr_i[6:2];
    assign req = cyc_i & stb_i & (q.bus == ADR_IDLE);

    always_comb begin
        next_q = q;
        next_q.restart = 1'b0;
        wr = 32'h0000_0000;
        half_osr = 13'h0010 << oversampling_ratio_i;
        // Offset correction is combinational so it costs no delay
        fixed = q.offset_en ? (conv_code_i + q.offset) : conv_code_i;
        new_data = 1'b0;
        stored = fixed;
        if (q.gain_en) begin
            // Gain path: hold the corrected code for the fixed group delay
            if (conv_valid_i) begin
                next_q.gain_busy = 1'b1;
                next_q.gain_cnt = 5'h00;
                next_q.gain_data = gain_fix_code_i;
            end else if (q.gain_busy && mod_tick_i) begin
                next_q.gain_cnt = q.gain_cnt + 5'h01;
                if (q.gain_cnt == 5'(`ADR_GAIN_FIX_DELAY - 1)) begin
                    next_q.gain_busy = 1'b0;
                    new_data = 1'b1;
                    stored = q.gain_data;
                end
            end
        end else begin
            next_q.gain_busy = 1'b0;
            new_data = conv_valid_i;
        end
        // Result capture: freeze during a serial read, take the newest after it
        if (new_data && serial_read_busy_i) begin
            next_q.pending = stored;
            next_q.pend_valid = 1'b1;
        end else if (new_data) begin
            next_q.result = stored;
            next_q.pend_valid = 1'b0;
        end else if (q.pend_valid && !serial_read_busy_i) begin
            next_q.result = q.pending;
            next_q.pend_valid = 1'b0;
        end
        if (new_data) begin
            next_q.status[`ADR_ST_READY] = 1'b0;
        end
        if (mod_tick_i) begin
            next_q.modbits = comparator_outputs_i;
        end
        if (q.start_cnt != 13'h0000 && mod_tick_i) begin
            next_q.start_cnt = q.start_cnt - 13'h0001;
        end
        if (crc_mismatch_i && q.status[`ADR_ST_INT_EN]) begin
            next_q.crc_alarm = 1'b1;
        end
        // Bus
        unique case (q.bus)
            ADR_IDLE: begin
                if (req) begin
                    next_q.bus = ADR_ACK;
                    next_q.rdata = 32'h0000_0000;
                    unique case (idx)
                        `ADR_IDX_RESULT: next_q.rdata = {8'h00, q.result};
                        `ADR_IDX_MODBITS: next_q.rdata = {28'h0, q.modbits};
                        `ADR_IDX_DELAY: next_q.rdata = {20'h0, q.delay};
                        `ADR_IDX_AMP: next_q.rdata = {29'h0, q.amp};
                        `ADR_IDX_STATUS: next_q.rdata = {8'h00, q.status};
                        `ADR_IDX_CTRL: next_q.rdata = {30'h0, q.offset_en, q.gain_en};
                        `ADR_IDX_OFFSET: next_q.rdata = {8'h00, q.offset};
                        `ADR_IDX_LOCK: next_q.rdata = {8'h00, q.lock, map_checksum_i};
                        default: next_q.rdata = 32'h0000_0000;
                    endcase
                    if (!we_i && idx == `ADR_IDX_STATUS && !new_data) begin
                        next_q.status[`ADR_ST_READY] = 1'b1;
                    end
                    if (we_i) begin
                        wr = lane_merge(next_q.rdata, dat_i, sel_i);
                        unique case (idx)
                            `ADR_IDX_MODBITS: next_q.modbits = wr[3:0];
                            `ADR_IDX_DELAY: begin
                                next_q.delay = wr[11:0] & 12'(`ADR_DELAY_MASK);
                                next_q.restart = 1'b1;
                                next_q.start_cnt = {1'b0, wr[11:0]} + half_osr;
                                next_q.pend_valid = 1'b0;
                                next_q.gain_busy = 1'b0;
                            end
                            `ADR_IDX_AMP: next_q.amp = wr[2:0] & 3'(`ADR_AMP_MASK);
                            `ADR_IDX_STATUS: begin
                                next_q.status = (wr[23:0] & `ADR_ST_WMASK) | (q.status & ~`ADR_ST_WMASK);
                                if (new_data) begin
                                    next_q.status[`ADR_ST_READY] = 1'b0;
                                end
                            end
                            `ADR_IDX_CTRL: begin
                                next_q.offset_en = wr[`ADR_CTRL_OFFSET_EN];
                                next_q.gain_en = wr[`ADR_CTRL_GAIN_EN];
                            end
                            `ADR_IDX_OFFSET: next_q.offset = wr[23:0];
                            `ADR_IDX_LOCK: begin
                                next_q.lock = wr[23:16];
                                // A mismatch with interrupt enabled in the same cycle as the unlock keeps the alarm set
                                if (wr[23:16] == `ADR_UNLOCK_KEY && !(crc_mismatch_i && q.status[`ADR_ST_INT_EN])) begin
                                    next_q.crc_alarm = 1'b0;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
            ADR_ACK: next_q.bus = ADR_IDLE;
            default: next_q.bus = ADR_IDLE;
        endcase
        if (rst_i) begin
            next_q = '0;
            next_q.status = `ADR_RST_STATUS;
            next_q.modbits = `ADR_RST_MODBITS;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    // ==========================================================================
    // Outputs
    assign dat_o = q.rdata;
    assign ack_o = (q.bus == ADR_ACK);
    assign conv_restart_o = q.restart;
    assign start_pending_o = (q.start_cnt != 13'h0000);
    assign amplifier_gain_o = amp_gain(q.amp);
    assign result_code_o = fmt_result(q.result, q.status[`ADR_ST_WIDTH_HI:`ADR_ST_WIDTH_LO]);
    assign read_incr_o = q.status[`ADR_ST_READ_HI:`ADR_ST_READ_LO];
    assign write_incr_o = q.status[`ADR_ST_WRITE];
    assign crc_wide_o = q.status[`ADR_ST_CRC_WIDE];
    assign transfer_checksum_enable_o = q.status[`ADR_ST_XFER_CRC];
    // Ready pin: low on data or alarm; idle level driven or released
    assign ready_pin_n_o = q.crc_alarm ? 1'b0 : q.status[`ADR_ST_READY];
    assign ready_pin_n_oe_o = q.crc_alarm | ~q.status[`ADR_ST_READY] | q.status[`ADR_ST_IDLE_DRIVE];
    assign bitstream_out_pin_o = q.status[`ADR_ST_BITSTREAM] & bitstream_i;

endmodule : adr_bank

// *** rtl/adr_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the result/status register bank
// Assumes: Wishbone byte address = 4 x register index
// Notes: Included by the package, by the bank module and by the checker module
`ifndef ADR_DEFINES_SVH
`define ADR_DEFINES_SVH

// ==========================================================================
// Register indexes
`define ADR_IDX_RESULT 5'h00
`define ADR_IDX_MODBITS 5'h08
`define ADR_IDX_DELAY 5'h0A
`define ADR_IDX_AMP 5'h0B
`define ADR_IDX_STATUS 5'h0C
`define ADR_IDX_CTRL 5'h0D
`define ADR_IDX_OFFSET 5'h0F
`define ADR_IDX_LOCK 5'h1F

// ==========================================================================
// Status and communication fields
`define ADR_ST_READ_HI 23
`define ADR_ST_READ_LO 22
`define ADR_ST_WRITE 21
`define ADR_ST_IDLE_DRIVE 20
`define ADR_ST_CRC_WIDE 18
`define ADR_ST_WIDTH_HI 17
`define ADR_ST_WIDTH_LO 16
`define ADR_ST_XFER_CRC 15
`define ADR_ST_INT_EN 14
`define ADR_ST_BITSTREAM 11
`define ADR_ST_READY 0
`define ADR_ST_WMASK 24'hF7C800

// ==========================================================================
// Reset values and field widths
`define ADR_RST_STATUS 24'hA10001
`define ADR_RST_MODBITS 4'h3
`define ADR_DELAY_MASK 24'h000FFF
`define ADR_AMP_MASK 24'h000007
`define ADR_UNLOCK_KEY 8'hA5
`define ADR_CTRL_OFFSET_EN 1
`define ADR_CTRL_GAIN_EN 0

// ==========================================================================
// Timing counts in modulator clock periods
`define ADR_GAIN_FIX_DELAY 24

`endif

// *** rtl/adr_pkg.sv ***
// Purpose: Types shared by the result/status register bank
// Assumes: adr_defines.svh holds all numbers
// Notes: None
package adr_pkg;
    `include "adr_defines.svh"

    typedef enum logic [1:0] {
        ADR_IDLE,
        ADR_ACK
    } adr_bus_st_t;

    typedef struct packed {
        logic [4:0] addr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
    } adr_wb_req_t;

    typedef struct packed {
        adr_bus_st_t bus;
        logic [31:0] rdata;
        logic [23:0] result;
        logic [23:0] pending;
        logic pend_valid;
        logic [3:0] modbits;
        logic [11:0] delay;
        logic [2:0] amp;
        logic [23:0] status;
        logic offset_en;
        logic gain_en;
        logic [23:0] offset;
        logic [7:0] lock;
        logic crc_alarm;
        logic restart;
        logic [12:0] start_cnt;
        logic [4:0] gain_cnt;
        logic gain_busy;
        logic [23:0] gain_data;
    } adr_state_t;
endpackage : adr_pkg

// *** sim/adr_core_model.sv ***
// Purpose: Converter core stand-in that feeds the register bank
// Assumes: One modulator tick every four clocks
// Notes: The code bus shows the inverse of its last value between results
`timescale 1ns/10ps
module adr_core_model (
    // Clock, reset and bench control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [23:0] code_i,
    input wire logic [3:0] comp_i,
    // Core outputs
    output logic mod_tick_o,
    output logic [3:0] comp_o,
    output logic conv_valid_o,
    output logic [23:0] code_o,
    output logic [23:0] gain_o,
    output logic bits_o
);
    logic [1:0] cnt;
    // ========================================
    // Tick, comparators and results
    assign gain_o = {code_o[22:0], 1'b0};
    always_ff @(posedge clk_i) begin
        cnt <= rst_i ? 2'h0 : cnt + 2'h1;
        mod_tick_o <= !rst_i && cnt == 2'h3;
        comp_o <= rst_i ? 4'h3 : (cnt == 2'h3 ? comp_i : comp_o);
        conv_valid_o <= go_i;
        code_o <= go_i ? code_i : ~code_o;
        bits_o <= cnt[1];
    end
endmodule : adr_core_model

// *** sim/adr_bank_chk.sv ***
// Purpose: Port-level checks of the result/status register bank
// Assumes: Bench drives full-word status writes through Wishbone
// Notes: Shadows the status and amplifier registers from bus writes
`timescale 1ns/10ps
`include "adr_defines.svh"
module adr_bank_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [6:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    // Core and pins
    input wire logic bitstream_i,
    input wire logic crc_mismatch_i,
    input wire logic conv_restart_o,
    input wire logic [5:0] amplifier_gain_o,
    input wire logic [1:0] read_incr_o,
    input wire logic write_incr_o,
    input wire logic crc_wide_o,
    input wire logic transfer_checksum_enable_o,
    input wire logic ready_pin_n_o,
    input wire logic ready_pin_n_oe_o,
    input wire logic bitstream_out_pin_o
);
    logic take;
    logic [23:0] st_q, wm;
    logic [2:0] amp_q;
    // ========================================
    // Shadow registers
    assign take = cyc_i && stb_i && !ack_o;
    assign wm = `ADR_ST_WMASK & {{8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= `ADR_RST_STATUS;
            amp_q <= 3'h0;
        end else if (take && we_i && adr_i == 7'h30) begin
            st_q <= (st_q & ~wm) | (dat_i[23:0] & wm);
        end else if (take && we_i && adr_i == 7'h2C && sel_i[0]) begin
            amp_q <= dat_i[2:0];
        end
    end
    // ========================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_delay_write;
        take && we_i && adr_i == 7'h28;
    endsequence
    a_ack_answer: assert property (take |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_delay_restart: assert property (s_delay_write |-> ##[1:3] conv_restart_o)
        else $error("no restart after start delay write");
    a_restart_pulse: assert property (conv_restart_o |=> !conv_restart_o)
        else $error("restart longer than one cycle");
    a_gain_map: assert property (amplifier_gain_o == (amp_q > 3'h5 ? 6'h01 : 6'h01 << amp_q))
        else $error("amplifier gain does not match code");
    a_mode_follow: assert property ({read_incr_o, write_incr_o, crc_wide_o, transfer_checksum_enable_o}
        == {st_q[23:21], st_q[18], st_q[15]})
        else $error("serial mode outputs differ from status");
    a_bits_gate: assert property (bitstream_out_pin_o == (bitstream_i && st_q[11]))
        else $error("bitstream pin not gated by enable");
    a_idle_drive: assert property (ready_pin_n_oe_o && ready_pin_n_o |-> st_q[20])
        else $error("ready pin driven high while idle drive off");
    a_alarm_low: assert property (crc_mismatch_i && st_q[14] |-> ##[1:3] (ready_pin_n_oe_o && !ready_pin_n_o))
        else $error("checksum alarm did not pull ready pin low");
endmodule : adr_bank_chk

bind adr_bank adr_bank_chk u_adr_bank_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .ack_o, .bitstream_i, .crc_mismatch_i, .conv_restart_o, .amplifier_gain_o, .read_incr_o, .write_incr_o,
    .crc_wide_o, .transfer_checksum_enable_o, .ready_pin_n_o, .ready_pin_n_oe_o, .bitstream_out_pin_o);

// *** sim/adr_bank_test.sv ***
// Purpose: Register-level test of the result/status bank
// Assumes: Model ticks every four clocks; checksum input held fixed
// Notes: Host writes ones to reserved status bits once and never writes modulator bits
`timescale 1ns/10ps
module adr_bank_test;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, go = 1'b0;
    logic serial_read_busy_i = 1'b0, crc_mismatch_i = 1'b0, ack_o, mod_tick_i, conv_valid_i, bitstream_i;
    logic conv_restart_o, start_pending_o, write_incr_o, crc_wide_o, transfer_checksum_enable_o;
    logic ready_pin_n_o, ready_pin_n_oe_o, bitstream_out_pin_o;
    logic [6:0] adr_i = 7'h00;
    logic [3:0] sel_i = 4'hF, comp = 4'h3, comparator_outputs_i;
    logic [31:0] dat_i = 32'h0, dat_o, result_code_o, rd;
    logic [23:0] code = 24'h0, conv_code_i, gain_fix_code_i;
    logic [2:0] oversampling_ratio_i = 3'h0;
    logic [15:0] map_checksum_i = 16'h1234;
    logic [5:0] amplifier_gain_o;
    logic [1:0] read_incr_o;
    logic [31:0] fx [4] = '{32'h8001, 32'h800123, 32'h80012300, 32'hFF800123};
    logic [31:0] fm [4] = '{32'hFFFF, 32'hFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
    int error_cnt = 0, cmp_count = 0, n;
    int pend_ticks = 0;
    always #5 clk_i = ~clk_i;
    // Counts the modulator periods in which the start delay counter runs
    always @(posedge clk_i) begin
        if (start_pending_o && mod_tick_i) pend_ticks <= pend_ticks + 1;
    end
    adr_core_model u_adr_core_model (.clk_i, .rst_i, .go_i(go), .code_i(code), .comp_i(comp),
        .mod_tick_o(mod_tick_i), .comp_o(comparator_outputs_i), .conv_valid_o(conv_valid_i),
        .code_o(conv_code_i), .gain_o(gain_fix_code_i), .bits_o(bitstream_i));
    adr_bank u_adr_bank (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .mod_tick_i, .comparator_outputs_i, .conv_valid_i, .conv_code_i, .gain_fix_code_i,
        .oversampling_ratio_i, .serial_read_busy_i, .crc_mismatch_i, .map_checksum_i, .conv_restart_o,
        .start_pending_o, .amplifier_gain_o, .result_code_o, .read_incr_o, .write_incr_o, .crc_wide_o,
        .transfer_checksum_enable_o, .bitstream_i, .ready_pin_n_o, .ready_pin_n_oe_o, .bitstream_out_pin_o);
    // ========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    // Request held until the rising edge at which ack is sampled high
    task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            error_cnt++;
            results();
        end
    endtask : acc
    task automatic conv(input logic [23:0] c);
        @(posedge clk_i);
        go <= 1'b1;
        code <= c;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : conv
    // ========================================
    // Sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(1'b0, 7'h30, 0); check(rd, 32'h00A10001);
        check({ready_pin_n_oe_o, ready_pin_n_o}, 2'b01);
        acc(1'b0, 7'h20, 0); check(rd, 32'h3);
        acc(1'b0, 7'h04, 0); check(rd, 0);
        comp <= 4'hA;
        repeat (12) @(posedge clk_i);
        acc(1'b0, 7'h20, 0); check(rd, 32'hA);
        for (n = 0; n < 8; n++) begin
            acc(1'b1, 7'h2C, 32'hFFFFFFF8 | n);
            acc(1'b0, 7'h2C, 0); check(rd, n);
            check(amplifier_gain_o, n > 5 ? 1 : 1 << n);
        end
        acc(1'b1, 7'h30, 32'h00FFCFFF);
        acc(1'b0, 7'h30, 0); check(rd, 32'h00F7C801);
        check({ready_pin_n_oe_o, ready_pin_n_o}, 2'b11);
        crc_mismatch_i <= 1'b1;
        @(posedge clk_i);
        crc_mismatch_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check({ready_pin_n_oe_o, ready_pin_n_o}, 2'b10);
        acc(1'b1, 7'h7C, 32'h00A50000); check({ready_pin_n_oe_o, ready_pin_n_o}, 2'b11);
        acc(1'b0, 7'h7C, 0); check(rd[15:0], 16'h1234);
        acc(1'b1, 7'h28, 32'hFFFFF005);
        n = pend_ticks;
        repeat (400) @(posedge clk_i);
        check(pend_ticks - n, 21);
        check(start_pending_o, 1'b0);
        acc(1'b0, 7'h28, 0); check(rd, 32'h005);
        conv(24'h800123);
        for (n = 0; n < 4; n++) begin
            acc(1'b1, 7'h30, (n << 22) | ((n ^ 2) << 16));
            check(result_code_o & fm[n ^ 2], fx[n ^ 2]);
        end
        acc(1'b0, 7'h00, 0); check(rd[23:0], 24'h800123);
        acc(1'b0, 7'h30, 0); check(rd[0], 1'b0);
        acc(1'b0, 7'h30, 0); check(rd[0], 1'b1);
        serial_read_busy_i <= 1'b1;
        conv(24'h000777);
        acc(1'b0, 7'h00, 0); check(rd[23:0], 24'h800123);
        serial_read_busy_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        acc(1'b0, 7'h00, 0); check(rd[23:0], 24'h000777);
        acc(1'b1, 7'h3C, 32'h10);
        acc(1'b1, 7'h34, 32'h2);
        conv(24'h000100);
        acc(1'b0, 7'h00, 0); check(rd[23:0], 24'h000110);
        acc(1'b1, 7'h34, 32'h1);
        acc(1'b0, 7'h30, 0);
        conv(24'h000200);
        repeat (76) @(posedge clk_i);
        acc(1'b0, 7'h30, 0); check(rd[0], 1'b1);
        repeat (24) @(posedge clk_i);
        acc(1'b0, 7'h00, 0); check(rd[23:0], 24'h000400);
        acc(1'b0, 7'h30, 0); check(rd[0], 1'b0);
        results();
    end
endmodule : adr_bank_test
